// ===== logic/rmie_defines.svh
// Offsets, field positions and reset values of the real mode entry unit
`ifndef RMIE_DEFINES_SVH
`define RMIE_DEFINES_SVH

// Register byte offsets on the bus
`define RMIE_OFF_CTRL    8'h00
`define RMIE_OFF_TBASE   8'h04
`define RMIE_OFF_TLIMIT  8'h08
`define RMIE_OFF_CS      8'h0c
`define RMIE_OFF_IP      8'h10
`define RMIE_OFF_FLAGS   8'h14
`define RMIE_OFF_SS      8'h18
`define RMIE_OFF_SP      8'h1c
`define RMIE_OFF_STATUS  8'h20

// Control and status fields
`define RMIE_CTRL_V86     0
`define RMIE_ST_BUSY      0
`define RMIE_ST_LIMIT     1
`define RMIE_ST_REFUSED   2
`define RMIE_ST_VEC_LO    8

// Flag bit positions in the flags register
`define RMIE_FL_TRAP    8
`define RMIE_FL_IF      9
`define RMIE_FL_RESUME  16
`define RMIE_FL_ALIGN   18

// Reset values
`define RMIE_TBASE_RST   32'h0000_0000
`define RMIE_TLIMIT_RST  16'h03ff
`define RMIE_FLAGS_RST   32'h0000_0002
`define RMIE_CS_RST      16'h0000

// Table and stack geometry
`define RMIE_ENT_BYTES   32'h0000_0004
`define RMIE_ENT_SEG     32'h0000_0002
`define RMIE_SEG_SHIFT   4
`define RMIE_STK_STEP    16'h0002
`define RMIE_VEC_INV_OP  8'h06

`endif

// ===== logic/rmie_entry.sv
// Real mode interrupt entry, return and opcode legality unit
// What this block does
// - The event's vector number selects one entry of the interrupt table.
// - Entry offset is vector times four, added to the table base.
// - Each entry is four bytes: 16-bit offset then code segment.
// - First push the code segment and the low 16 bits of IP.
// - Then push only the low 16 bits of the flags register.
// - After saving state, clear the interrupt-enable flag.
// - Also clear single-step trap, resume and alignment-check flags.
// - Finally load code segment and IP from the entry and continue.
// - Interrupt return pops the saved flags, IP and code segment.
// - No error code is ever pushed in real mode.
// - After reset the table base is 0 and the limit is 3ffh.
// - Base and limit live in two registers loaded by software.
// - Unlisted opcodes raise the invalid opcode exception, vector 6.
// - Later extension instructions execute in real mode without fault.
// - The 32-bit operand prefix selects full 32-bit registers.
// - Real mode raises only vectors 0-8, 12, 13, 16, 18, 32-255.
// - Virtual mode may also raise vectors 10, 11, 14 and 17.
// - Virtual mode hands events to the protected-mode mechanism instead.
// - Linear address is segment shifted left four plus offset.
`timescale 1ns/1ps
`default_nettype none
`include "rmie_defines.svh"

module rmie_entry
  import rmie_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Wishbone register slave
  input  wire logic          wb_cyc,
  input  wire logic          wb_stb,
  input  wire logic          wb_we,
  input  wire logic [7:0]    wb_adr,
  input  wire logic [3:0]    wb_sel,
  input  wire logic [31:0]   wb_dat_w,
  output logic      [31:0]   wb_dat_r,
  output logic               wb_ack,
  // Interrupt and exception requests
  input  wire rmie_event_t   ev,
  output logic               ev_ready,
  input  wire logic          interrupt_return_instruction,
  // Decoded opcode check
  input  wire logic          op_valid,
  input  wire logic [7:0]    op_byte0,
  input  wire logic [7:0]    op_byte1,
  input  wire logic          op_prefix32,
  output logic               op_wide,
  output logic               invalid_opcode_exception,
  // Memory port for table and stack
  output rmie_mem_req_t      mem,
  input  wire logic [15:0]   mem_dat_r,
  input  wire logic          mem_ack,
  // Protected-mode handoff and completion
  output rmie_event_t        pm,
  output logic               done
);

  rmie_core_t r;
  rmie_core_t n;
  logic [31:0] wmask;

  // Byte enables expand to a write mask
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g +: 8] = {8{wb_sel[g]}};
    end
  endgenerate

  function automatic logic [31:0] mrg(input logic [31:0] old,
                                      input logic [31:0] nw,
                                      input logic [31:0] m);
    mrg = (old & ~m) | (nw & m);
  endfunction

  function automatic logic [31:0] lin(input logic [15:0] seg,
                                      input logic [15:0] off);
    lin = ({16'h0000, seg} << `RMIE_SEG_SHIFT) + {16'h0000, off};
  endfunction

  function automatic logic vec_ok(input logic [7:0] v, input logic v86);
    case (v)
      8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
      8'h0c, 8'h0d, 8'h10, 8'h12: vec_ok = 1'b1;
      8'h0a, 8'h0b, 8'h0e, 8'h11: vec_ok = v86;
      default: vec_ok = (v >= 8'h20);
    endcase
  endfunction

  function automatic logic legal_op(input logic [7:0] b0,
                                    input logic [7:0] b1);
    if (b0 == 8'h0f) begin
      case (b1)
        8'h01, 8'h06, 8'h08, 8'h09, 8'h20, 8'h21, 8'h22, 8'h23,
        8'h30, 8'h31, 8'h32, 8'h33, 8'ha0, 8'ha1, 8'ha2, 8'ha3,
        8'ha4, 8'ha5, 8'ha8, 8'ha9, 8'hab, 8'hac, 8'had, 8'haf,
        8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6, 8'hb7,
        8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hc0, 8'hc1,
        8'hc7: legal_op = 1'b1;
        default: legal_op = (b1[7:4] == 4'h8) || (b1[7:4] == 4'h9) ||
                            (b1[7:3] == 5'h19);
      endcase
    end else begin
      legal_op = !((b0 == 8'h63) || (b0 == 8'hd6));
    end
  endfunction

  always_comb begin
    logic        take;
    logic [7:0]  tvec;
    logic [31:0] eoff;
    logic [15:0] sp_dn;
    logic [31:0] madr;
    logic [15:0] mdat;
    logic        mwe;
    logic        is_mem;
    take   = 1'b0;
    tvec   = 8'h00;
    sp_dn  = r.sp - `RMIE_STK_STEP;
    eoff   = {24'h000000, r.vec} * `RMIE_ENT_BYTES;
    madr   = 32'h0000_0000;
    mdat   = 16'h0000;
    mwe    = 1'b0;
    is_mem = 1'b1;
    n = r;
    n.done     = 1'b0;
    n.invalid_opcode_exception = 1'b0;
    n.pm.valid = 1'b0;
    n.wb_ack   = wb_cyc && wb_stb && !r.wb_ack;
    n.wb_rd    = 32'h0000_0000;

    // Register access, one cycle answer
    if (n.wb_ack && !wb_we) begin
      case (wb_adr)
        `RMIE_OFF_CTRL:   n.wb_rd = {31'h0, r.v86};
        `RMIE_OFF_TBASE:  n.wb_rd = r.tbase;
        `RMIE_OFF_TLIMIT: n.wb_rd = {16'h0000, r.tlimit};
        `RMIE_OFF_CS:     n.wb_rd = {16'h0000, r.cs};
        `RMIE_OFF_IP:     n.wb_rd = r.ip;
        `RMIE_OFF_FLAGS:  n.wb_rd = r.fl;
        `RMIE_OFF_SS:     n.wb_rd = {16'h0000, r.ss};
        `RMIE_OFF_SP:     n.wb_rd = {16'h0000, r.sp};
        `RMIE_OFF_STATUS: n.wb_rd = {16'h0000, r.vec, 5'h00, r.refused,
                                     r.limit_err, (r.st != S_IDLE)};
        default:          n.wb_rd = 32'h0000_0000;
      endcase
    end
    if (n.wb_ack && wb_we) begin
      if (wb_adr == `RMIE_OFF_STATUS) begin
        if (wb_sel[0] && wb_dat_w[`RMIE_ST_LIMIT])
          n.limit_err = 1'b0;
        if (wb_sel[0] && wb_dat_w[`RMIE_ST_REFUSED])
          n.refused = 1'b0;
      end else if (r.st == S_IDLE) begin
        case (wb_adr)
          `RMIE_OFF_CTRL: begin
            if (wb_sel[0]) n.v86 = wb_dat_w[`RMIE_CTRL_V86];
          end
          `RMIE_OFF_TBASE:  n.tbase = mrg(r.tbase, wb_dat_w, wmask);
          `RMIE_OFF_TLIMIT: n.tlimit = 16'(mrg({16'h0000, r.tlimit},
                                               wb_dat_w, wmask));
          `RMIE_OFF_CS:     n.cs = 16'(mrg({16'h0000, r.cs},
                                           wb_dat_w, wmask));
          `RMIE_OFF_IP:     n.ip = mrg(r.ip, wb_dat_w, wmask);
          `RMIE_OFF_FLAGS:  n.fl = mrg(r.fl, wb_dat_w, wmask);
          `RMIE_OFF_SS:     n.ss = 16'(mrg({16'h0000, r.ss},
                                           wb_dat_w, wmask));
          `RMIE_OFF_SP:     n.sp = 16'(mrg({16'h0000, r.sp},
                                           wb_dat_w, wmask));
          default: ;
        endcase
      end
    end

    // Memory request contents per state
    case (r.st)
      S_PUSH_CS: begin madr = lin(r.ss, sp_dn); mdat = r.cs; mwe = 1'b1; end
      S_PUSH_IP: begin
        madr = lin(r.ss, sp_dn);
        mdat = r.ip[15:0];
        mwe  = 1'b1;
      end
      S_PUSH_FL: begin
        madr = lin(r.ss, sp_dn);
        mdat = r.fl[15:0];
        mwe  = 1'b1;
      end
      S_RD_OFF: madr = r.tbase + eoff;
      S_RD_SEG: madr = r.tbase + eoff + `RMIE_ENT_SEG;
      S_POP_FL, S_POP_IP, S_POP_CS: madr = lin(r.ss, r.sp);
      default:  is_mem = 1'b0;
    endcase
    if (is_mem && !r.mem.cyc) begin
      n.mem.cyc = 1'b1;
      n.mem.we  = mwe;
      n.mem.adr = madr;
      n.mem.dat = mdat;
    end

    if (r.mem.cyc && mem_ack) begin
      n.mem.cyc = 1'b0;
      n.mem.we  = 1'b0;
      case (r.st)
        S_PUSH_CS: begin n.sp = sp_dn; n.st = S_PUSH_IP; end
        S_PUSH_IP: begin n.sp = sp_dn; n.st = S_PUSH_FL; end
        S_PUSH_FL: begin
          n.sp = sp_dn;
          n.fl[`RMIE_FL_IF] = 1'b0;
          n.fl[`RMIE_FL_TRAP] = 1'b0;
          n.fl[`RMIE_FL_RESUME] = 1'b0;
          n.fl[`RMIE_FL_ALIGN] = 1'b0;
          n.st = S_RD_OFF;
        end
        S_RD_OFF: begin n.new_ip = mem_dat_r; n.st = S_RD_SEG; end
        S_RD_SEG: begin
          n.cs   = mem_dat_r;
          n.ip   = {16'h0000, r.new_ip};
          n.done = 1'b1;
          n.st   = S_IDLE;
        end
        S_POP_FL: begin
          n.fl[15:0] = mem_dat_r;
          n.sp = r.sp + `RMIE_STK_STEP;
          n.st = S_POP_IP;
        end
        S_POP_IP: begin
          n.ip = {16'h0000, mem_dat_r};
          n.sp = r.sp + `RMIE_STK_STEP;
          n.st = S_POP_CS;
        end
        S_POP_CS: begin
          n.cs   = mem_dat_r;
          n.sp   = r.sp + `RMIE_STK_STEP;
          n.done = 1'b1;
          n.st   = S_IDLE;
        end
        default: n.st = S_IDLE;
      endcase
    end

    // New work is taken only while idle
    if (r.st == S_IDLE) begin
      if (interrupt_return_instruction) begin
        n.st = S_POP_FL;
      end else if (op_valid) begin
        n.wide = op_prefix32;
        if (!legal_op(op_byte0, op_byte1)) begin
          n.invalid_opcode_exception = 1'b1;
          take = 1'b1;
          tvec = `RMIE_VEC_INV_OP;
        end
      end else if (ev.valid) begin
        take = 1'b1;
        tvec = ev.vector;
      end
    end
    if (take) begin
      if (!vec_ok(tvec, r.v86)) begin
        n.refused = 1'b1;
      end else if (r.v86) begin
        n.pm.valid  = 1'b1;
        n.pm.vector = tvec;
      end else if ({24'h000000, tvec} * `RMIE_ENT_BYTES +
                   `RMIE_ENT_BYTES - 32'h1 > {16'h0000, r.tlimit}) begin
        n.limit_err = 1'b1;
      end else begin
        n.vec = tvec;
        n.st  = S_PUSH_CS;
      end
    end
    n.ev_ready = (n.st == S_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r          <= '0;
      r.st       <= S_IDLE;
      r.tbase    <= `RMIE_TBASE_RST;
      r.tlimit   <= `RMIE_TLIMIT_RST;
      r.fl       <= `RMIE_FLAGS_RST;
      r.cs       <= `RMIE_CS_RST;
      r.ev_ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_r = r.wb_rd;
  assign wb_ack   = r.wb_ack;
  assign ev_ready = r.ev_ready;
  assign op_wide  = r.wide;
  assign invalid_opcode_exception = r.invalid_opcode_exception;
  assign mem      = r.mem;
  assign pm       = r.pm;
  assign done     = r.done;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  reset_table_a: assert property (
    !$past(rst_n) |-> r.tbase == 32'h0 && r.tlimit == 16'h03ff)
    else $error("table base or limit wrong after reset");

  table_index_a: assert property (
    r.st == S_RD_OFF && $rose(r.mem.cyc) |->
      r.mem.adr == r.tbase + {22'h0, r.vec, 2'b00} && !r.mem.we)
    else $error("table entry address not base plus four times vector");

  entry_seg_a: assert property (
    r.st == S_RD_SEG && $rose(r.mem.cyc) |->
      r.mem.adr == r.tbase + {22'h0, r.vec, 2'b00} + 32'h2)
    else $error("segment word not two bytes into the entry");

  push_order_a: assert property (
    r.st == S_PUSH_CS && r.mem.cyc && mem_ack |=>
      r.st == S_PUSH_IP && !r.mem.cyc ##1
      r.mem.cyc && r.mem.we && r.mem.dat == r.ip[15:0])
    else $error("low IP not pushed after code segment");

  flags_push_a: assert property (
    r.st == S_PUSH_FL && $rose(r.mem.cyc) |->
      r.mem.dat == r.fl[15:0] && r.mem.we)
    else $error("pushed flags image is not the low flags half");

  flags_clear_a: assert property (
    r.st == S_PUSH_FL && r.mem.cyc && mem_ack |=>
      r.st == S_RD_OFF && !r.fl[9] && !r.fl[8] && !r.fl[16] && !r.fl[18])
    else $error("entry flags not cleared or extra push made");

  handler_jump_a: assert property (
    r.st == S_RD_SEG && r.mem.cyc && mem_ack |=>
      r.done && r.cs == $past(mem_dat_r) && r.ip[15:0] == $past(r.new_ip))
    else $error("handler address not loaded from the entry");

  sp_step_a: assert property (
    (r.st == S_PUSH_CS || r.st == S_PUSH_IP || r.st == S_PUSH_FL) &&
    $rose(r.mem.cyc) |->
      r.mem.adr == ({16'h0, r.ss} << 4) + {16'h0, r.sp - 16'h2})
    else $error("push slot not below stack pointer");

  return_path_a: assert property (
    r.st == S_IDLE && interrupt_return_instruction |=> r.st == S_POP_FL ##1
      r.mem.cyc && !r.mem.we)
    else $error("return does not start popping");

  bad_op_raise_a: assert property (
    r.st == S_IDLE && !interrupt_return_instruction && op_valid &&
    op_byte0 == 8'h63 && !r.v86 && r.tlimit >= 16'h001b |=>
      r.invalid_opcode_exception && r.vec == 8'h06 && r.st == S_PUSH_CS)
    else $error("illegal opcode did not enter vector six");

  ext_ok_a: assert property (
    r.st == S_IDLE && !interrupt_return_instruction && op_valid &&
    op_byte0 == 8'h0f && op_byte1 == 8'ha2 |=>
      !r.invalid_opcode_exception && r.st == S_IDLE)
    else $error("extension instruction faulted");

  reserved_vec_a: assert property (
    r.st == S_IDLE && !interrupt_return_instruction && !op_valid &&
    ev.valid && ev.vector == 8'h0e && !r.v86 |=>
      r.refused && r.st == S_IDLE && !r.pm.valid)
    else $error("reserved vector raised in real mode");

  v86_handoff_a: assert property (
    r.pm.valid |-> $past(r.v86) && r.st == S_IDLE && !r.mem.cyc)
    else $error("handoff outside virtual mode or with table access");

endmodule
`default_nettype wire

// ===== logic/rmie_pkg.sv
// Types shared by the real mode entry unit and its surroundings
`default_nettype none
package rmie_pkg;

  typedef enum logic [8:0] {
    S_IDLE    = 9'h001,
    S_PUSH_CS = 9'h002,
    S_PUSH_IP = 9'h004,
    S_PUSH_FL = 9'h008,
    S_RD_OFF  = 9'h010,
    S_RD_SEG  = 9'h020,
    S_POP_FL  = 9'h040,
    S_POP_IP  = 9'h080,
    S_POP_CS  = 9'h100
  } rmie_state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  vector;
  } rmie_event_t;

  typedef struct packed {
    logic        cyc;
    logic        we;
    logic [31:0] adr;
    logic [15:0] dat;
  } rmie_mem_req_t;

  typedef struct packed {
    rmie_state_t   st;
    logic [31:0]   tbase;
    logic [15:0]   tlimit;
    logic          v86;
    logic [15:0]   cs;
    logic [31:0]   ip;
    logic [31:0]   fl;
    logic [15:0]   ss;
    logic [15:0]   sp;
    logic [7:0]    vec;
    logic [15:0]   new_ip;
    logic          limit_err;
    logic          refused;
    rmie_mem_req_t mem;
    rmie_event_t   pm;
    logic          done;
    logic          invalid_opcode_exception;
    logic          wide;
    logic          ev_ready;
    logic          wb_ack;
    logic [31:0]   wb_rd;
  } rmie_core_t;

endpackage
`default_nettype wire

// ===== testbench/rmie_mem_model.sv
// Behavioural memory holding vector table and stack
`timescale 1ns/1ps
`default_nettype none
module rmie_mem_model
  import rmie_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Memory port
  input  wire rmie_mem_req_t mem,
  input  wire logic [3:0]    lat,
  output logic      [15:0]   mem_dat_r,
  output logic               mem_ack
);
  logic [15:0] ram [logic [31:0]];
  logic [3:0]  wait_q;

  // Read data outside an answer changes every cycle
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_dat_r <= ~mem_dat_r;
    if (!rst_n) begin
      wait_q <= 4'h0;
      mem_dat_r <= 16'h5a5a;
    end else if (mem.cyc && !mem_ack) begin
      if (wait_q < lat) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        mem_ack <= 1'b1;
        if (mem.we) begin
          ram[mem.adr] = mem.dat;
        end else begin
          mem_dat_r <= ram.exists(mem.adr) ? ram[mem.adr] : 16'h0000;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the real mode interrupt entry unit
`timescale 1ns/1ps
`default_nettype none
`include "rmie_defines.svh"
module tb
  import rmie_pkg::*;
;
  localparam logic [31:0] clr_m = (32'h1 << `RMIE_FL_IF)
    | (32'h1 << `RMIE_FL_TRAP) | (32'h1 << `RMIE_FL_RESUME)
    | (32'h1 << `RMIE_FL_ALIGN);
  logic          core_clk = 1'b0;
  logic          rst_n, wb_cyc, wb_stb, wb_we, wb_ack, ev_ready;
  logic          interrupt_return_instruction, invalid_opcode_exception;
  logic          op_valid, op_prefix32, op_wide, mem_ack, done;
  logic [7:0]    wb_adr, op_byte0, op_byte1, pm_v;
  logic [3:0]    wb_sel, lat;
  logic [31:0]   wb_dat_w, wb_dat_r, tb_base, q;
  logic [15:0]   mem_dat_r;
  rmie_event_t   ev, pm;
  rmie_mem_req_t mem;
  int            bad_count, cmp_count, done_n, bad_op_n, pm_n;

  always #2.5 core_clk = ~core_clk;

  rmie_entry dut_u (.core_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .ev, .ev_ready,
    .interrupt_return_instruction, .op_valid, .op_byte0, .op_byte1,
    .op_prefix32, .op_wide, .invalid_opcode_exception, .mem,
    .mem_dat_r, .mem_ack, .pm, .done);
  rmie_mem_model mem_u (.core_clk, .rst_n, .mem, .lat, .mem_dat_r,
    .mem_ack);

  // Pulse counters
  always @(posedge core_clk) begin
    if (done === 1'b1) done_n++;
    if (invalid_opcode_exception === 1'b1) bad_op_n++;
    if (pm.valid === 1'b1) begin
      pm_n++;
      pm_v = pm.vector;
    end
  end

  function automatic logic [31:0] lin(input logic [15:0] s,
                                      input logic [15:0] o);
    return {12'h0, s, 4'h0} + {16'h0, o};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= s;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r;
    chk("bus ack", 1, n < 50);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rdm(input string nm, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, q & m);
  endtask

  task automatic wt(ref int c, input int o, input string nm);
    int n;
    n = 0;
    while (c == o && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    chk(nm, 1, n < 500);
  endtask

  task automatic raise(input logic [7:0] v);
    int n;
    n = 0;
    ev.vector <= v;
    ev.valid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (ev_ready !== 1'b1 && n < 500);
    ev.valid <= 1'b0;
  endtask

  task automatic ent(input logic [7:0] v, input logic [15:0] sp);
    logic [15:0] ss, cs, off, sg, s2, s4, s6;
    logic [31:0] ip, fl, fe, t;
    int          o;
    ss = 16'($urandom);
    cs = 16'($urandom);
    off = 16'($urandom);
    sg = 16'($urandom);
    ip = $urandom;
    fl = ($urandom & 32'h0000_0cd5) | clr_m | 32'h2;
    fe = fl & ~clr_m;
    s2 = sp - 16'h2;
    s4 = sp - 16'h4;
    s6 = sp - 16'h6;
    t = tb_base + {22'h0, v, 2'b00};
    mem_u.ram[t] = off;
    mem_u.ram[t + 32'h2] = sg;
    lat <= 4'($urandom % 4);
    wr(`RMIE_OFF_SS, {16'h0, ss});
    wr(`RMIE_OFF_SP, {16'h0, sp});
    wr(`RMIE_OFF_CS, {16'h0, cs});
    wr(`RMIE_OFF_IP, ip);
    wr(`RMIE_OFF_FLAGS, fl);
    o = done_n;
    raise(v);
    wt(done_n, o, "entry done");
    chk("push cs", {16'h0, cs}, mem_u.ram[lin(ss, s2)]); // segment
    chk("push ip", ip & 32'hffff, mem_u.ram[lin(ss, s4)]); // ip
    chk("push fl", fl & 32'hffff, mem_u.ram[lin(ss, s6)]); // low flags
    rdm("sp", `RMIE_OFF_SP, 32'hffff, {16'h0, s6}); // no code
    rdm("cs", `RMIE_OFF_CS, 32'hffff, {16'h0, sg}); // segment
    rdm("ip", `RMIE_OFF_IP, '1, {16'h0, off}); // offset
    rdm("fl", `RMIE_OFF_FLAGS, '1, fe); // flags cleared
    rdm("vec", `RMIE_OFF_STATUS, 32'hff00, {16'h0, v, 8'h0}); // index
    o = done_n;
    interrupt_return_instruction <= 1'b1;
    @(posedge core_clk);
    interrupt_return_instruction <= 1'b0;
    wt(done_n, o, "return done");
    rdm("ret cs", `RMIE_OFF_CS, 32'hffff, {16'h0, cs}); // segment
    rdm("ret ip", `RMIE_OFF_IP, '1, ip & 32'hffff); // pointer
    rdm("ret fl", `RMIE_OFF_FLAGS, '1, {fe[31:16], fl[15:0]}); // flags
    rdm("ret sp", `RMIE_OFF_SP, 32'hffff, {16'h0, sp}); // stack
  endtask

  task automatic opc(input logic [17:0] t);
    int o, u;
    o = done_n;
    u = bad_op_n;
    op_byte0 <= t[15:8];
    op_byte1 <= t[7:0];
    op_prefix32 <= t[16];
    op_valid <= 1'b1;
    @(posedge core_clk);
    op_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("bad op", {31'h0, t[17]}, bad_op_n - u); // legality
    if (t[17]) begin
      wt(done_n, o, "bad op entry");
      rdm("bad op vec", `RMIE_OFF_STATUS, 32'hff00, 32'h0600); // vector
    end else begin
      chk("wide", {31'h0, t[16]}, {31'h0, op_wide}); // wide regs
    end
  endtask

  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  initial begin
    int         o;
    logic [7:0] okv [14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 13, 16, 18, 32};
    logic [7:0] rsv [8] = '{9, 10, 11, 14, 15, 17, 19, 31};
    logic [7:0] vmv [5] = '{10, 11, 14, 17, 6};
    logic [17:0] opt [10] = '{18'h26300, 18'h2d600, 18'h20f0b,
      18'h00fa2, 18'h10fb2, 18'h00f20, 18'h10f21, 18'h19000,
      18'h00f01, 18'h10100};
    {wb_cyc, wb_stb, wb_we, op_valid, op_prefix32} = '0;
    interrupt_return_instruction = 1'b0;
    {wb_adr, op_byte0, op_byte1, wb_sel, lat, wb_dat_w} = '0;
    ev = '0;
    rst_n = 1'b0;
    void'($urandom(27315));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rdm("base", `RMIE_OFF_TBASE, '1, 32'h0); // base
    rdm("limit", `RMIE_OFF_TLIMIT, '1, 32'h3ff); // limit
    rdm("flags", `RMIE_OFF_FLAGS, '1, 32'h2);
    rdm("hole", 8'h24, '1, 32'h0);
    wr(`RMIE_OFF_IP, '1);
    wb(1'b1, `RMIE_OFF_IP, 32'h0, 4'h3);
    rdm("sel", `RMIE_OFF_IP, '1, 32'hffff0000);
    tb_base = 32'h0;
    ent(8'h00, 16'h0000); // default table
    ent(8'hff, 16'h1000);
    tb_base = $urandom & 32'h000f_fffc;
    wr(`RMIE_OFF_TBASE, tb_base); // relocated
    for (int i = 0; i < 14; i++) ent(okv[i], 16'($urandom) & 16'hfffe);
    repeat (4) ent(8'(32 + $urandom % 224), 16'($urandom) & 16'hfffe);
    wr(`RMIE_OFF_TLIMIT, 32'h22);
    raise(8'h08);
    repeat (3) @(posedge core_clk);
    rdm("lim err", `RMIE_OFF_STATUS, 32'h2, 32'h2); // limit
    wr(`RMIE_OFF_STATUS, 32'h2);
    rdm("lim clr", `RMIE_OFF_STATUS, 32'h2, 32'h0);
    wr(`RMIE_OFF_TLIMIT, 32'h23);
    ent(8'h08, 16'h0200);
    wr(`RMIE_OFF_TLIMIT, 32'h3ff);
    foreach (rsv[i]) begin
      o = done_n;
      raise(rsv[i]);
      repeat (3) @(posedge core_clk);
      rdm("refused", `RMIE_OFF_STATUS, 32'h4, 32'h4); // reserved
      chk("no entry", o, done_n); // reserved
      wr(`RMIE_OFF_STATUS, 32'h4);
    end
    foreach (opt[i]) opc(opt[i]);
    wr(`RMIE_OFF_CTRL, 32'h1);
    foreach (vmv[i]) begin
      o = pm_n;
      raise(vmv[i]);
      wt(pm_n, o, "handoff");
      chk("pm vec", {24'h0, vmv[i]}, {24'h0, pm_v}); // handoff
    end
    wr(`RMIE_OFF_CTRL, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
